// ==== shared/usb_sr_consts.svh ====
// Register map, field positions, reset values and timing for the suspend/resume block
`ifndef USB_SR_CONSTS_SVH
`define USB_SR_CONSTS_SVH

`define CTRL_IDX            8'h00
`define IRQ_STAT_IDX        8'h01
`define IRQ_CLR_IDX         8'h02
`define IRQ_EN_IDX          8'h03
`define BANK0_IDX           8'h0A
`define BANK1_IDX           8'h1A

`define CTRL_ON_BIT         0
`define CTRL_DISC_BIT       1
`define CTRL_RESUME_REQ_BIT 2
`define CTRL_W              3
`define CTRL_RESET          3'h0

`define IRQ_IDLE_BIT        0
`define IRQ_WAKE_BIT        1
`define IRQ_DONE_BIT        2
`define IRQ_W               3
`define IRQ_RESET           3'h0

`define BANK_CRC_BIT        0
`define BANK_FLOW_BIT       1
`define BANK_W              2
`define BANK_RESET          2'h0

`define LINE_J              2'h2
`define LINE_K              2'h1

`define CNT_W               17
`define CLK_MHZ             25
`define SUSPEND_IDLE_US     3000
`define RESUME_IDLE_US      5000
`define RESUME_K_US         2000

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== shared/usb_sr_pkg.sv ====
// Types and line-state decoding for the suspend/resume block
`include "usb_sr_consts.svh"

package usb_sr_pkg;

  typedef enum logic [2:0] {
    st_off,
    st_active,
    st_suspend,
    st_wait,
    st_drive
  } link_state_t;

  // Line state as {dp, dm}
  typedef logic [1:0] line_t;

  function automatic logic line_is_j(input line_t l);
    return l == `LINE_J;
  endfunction

  function automatic logic line_is_k(input line_t l);
    return l == `LINE_K;
  endfunction

endpackage

// ==== shared/idle_timer_if.sv ====
// Interface between the link state machine and its interval timer
`timescale 1ns/1ps
`include "usb_sr_consts.svh"

interface idle_timer_if;
  logic              run;
  logic [`CNT_W-1:0] limit;
  logic              done;
  modport ctrl  (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface

// ==== hdl/sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module sync2 #(
  parameter int W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule

// ==== hdl/idle_timer.sv ====
// Interval timer: counts while run is high, pulses done at the limit
`timescale 1ns/1ps
`include "usb_sr_consts.svh"

module idle_timer (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  idle_timer_if.timer tmr_if
);
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cnt_d;
  logic              done_q;
  logic              done_d;

  // Restart after done so a following interval starts from zero
  always_comb begin
    cnt_d = cnt_q;
    if (!tmr_if.run || done_q) begin
      cnt_d = '0;
    end else if (cnt_q != tmr_if.limit) begin
      cnt_d = cnt_q + 1'b1;
    end
    done_d = tmr_if.run && !done_q && (cnt_d == tmr_if.limit);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign tmr_if.done = done_q;
endmodule

// ==== hdl/usb_suspend_resume_ctrl.sv ====
// USB full-speed suspend, wake and remote-resume control with host bank status
//
// Contract
// - On bus suspend, set the bus-idle flag and idle the pad.
// - Non-idle line while suspended sets the wake flag and reactivates the pad.
// - Pad idles while controller off or disconnect bit is one.
// - Pad returns active only when controller on and disconnect zero.
// - Upstream resume is our only own signalling; host enables it first.
// - No upstream resume unless the bus-idle flag is already set.
// - Writing one to the resume request starts resume signalling to the host.
// - Resume waits for 5 ms of bus inactivity, then goes out automatically.
// - Sending resume sets the wake flag and clears the bus-idle flag.
// - The resume request bit clears itself when signalling ends.
// - End of host-rebroadcast resume sets the resume-done flag; code sets it only after a host K woke the link, not after own resume.
// - Host mode: bank flow bit reads 1 after a flow error, else 0.
// - NAK on a non-isochronous bank transfer is a flow error.
// - Isochronous IN overrun or OUT underflow is a flow error.
// - CRC error on isochronous IN bank sets its checksum bit.
`timescale 1ns/1ps
`include "usb_sr_consts.svh"

module usb_suspend_resume_ctrl
  import usb_sr_pkg::*;
#(
  parameter int SUSPEND_IDLE_CYC = `SUSPEND_IDLE_US * `CLK_MHZ,
  parameter int RESUME_IDLE_CYC  = `RESUME_IDLE_US * `CLK_MHZ,
  parameter int RESUME_K_CYC     = `RESUME_K_US * `CLK_MHZ
) (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        usb_dp_in,
  input  wire logic        usb_dm_in,
  output logic             usb_dp_out,
  output logic             usb_dm_out,
  output logic             usb_oe_out,
  output logic             pad_idle_out,
  input  wire logic        host_mode_in,
  input  wire logic [1:0]  bank_nak_in,
  input  wire logic [1:0]  bank_overrun_in,
  input  wire logic [1:0]  bank_underflow_in,
  input  wire logic [1:0]  bank_crc_in,
  input  wire logic [1:0]  bank_iso_in,
  input  wire logic [1:0]  bank_rx_dir_in,
  output logic             irq_out
);

  localparam logic [7:0] BANK_IDX [2] = '{`BANK0_IDX, `BANK1_IDX};

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  line_t line;

  sync2 #(.W(2)) u_line_sync (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .d_in     ({usb_dp_in, usb_dm_in}),
    .q_out    (line)
  );

  idle_timer_if tmr ();

  idle_timer u_timer (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .tmr_if   (tmr)
  );

  // Word index decode; upper address bits must be zero to hit
  function automatic logic addr_hit(input logic [11:0] a, input logic [7:0] idx);
    return (a[11:10] == 2'h0) && (a[9:2] == idx);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    return addr_hit(a, `CTRL_IDX) || addr_hit(a, `IRQ_STAT_IDX) ||
           addr_hit(a, `IRQ_CLR_IDX) || addr_hit(a, `IRQ_EN_IDX) ||
           addr_hit(a, BANK_IDX[0]) || addr_hit(a, BANK_IDX[1]);
  endfunction

  // AXI4-Lite write channel: address and data held in either order
  logic        aw_full_q, aw_full_d;
  logic        w_full_q, w_full_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        do_wr;

  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid_in && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_q) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata_in;
      wstrb_d  = s_axi_wstrb_in;
    end
    if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // Register write strobes; only byte lane 0 carries fields
  logic wr_ctrl, wr_clr, wr_en;
  logic [1:0] wr_bank;

  function automatic logic s_axi_wstrb_ok(input logic [3:0] s);
    return s[0];
  endfunction

  assign wr_ctrl = do_wr && s_axi_wstrb_ok(wstrb_q) && addr_hit(awaddr_q, `CTRL_IDX);
  assign wr_clr  = do_wr && s_axi_wstrb_ok(wstrb_q) && addr_hit(awaddr_q, `IRQ_CLR_IDX);
  assign wr_en   = do_wr && s_axi_wstrb_ok(wstrb_q) && addr_hit(awaddr_q, `IRQ_EN_IDX);

  // Host pipe bank status, one copy per bank
  logic [`BANK_W-1:0] bank_val [2];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic [`BANK_W-1:0] st_q, st_d;
    logic               flow_ev, crc_ev;

    assign wr_bank[b] = do_wr && wstrb_q[0] && addr_hit(awaddr_q, BANK_IDX[b]);

    always_comb begin
      flow_ev = host_mode_in && (bank_iso_in[b] ?
                (bank_rx_dir_in[b] ? bank_overrun_in[b]
                                   : bank_underflow_in[b])
                : bank_nak_in[b]);
      crc_ev  = host_mode_in && bank_iso_in[b] && bank_rx_dir_in[b] && bank_crc_in[b];
      st_d = st_q;
      if (wr_bank[b]) begin
        st_d = wdata_q[`BANK_W-1:0];
      end
      // A fault in the write cycle still lands
      if (flow_ev) begin
        st_d[`BANK_FLOW_BIT] = 1'b1;
      end
      if (crc_ev) begin
        st_d[`BANK_CRC_BIT] = 1'b1;
      end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        st_q <= `BANK_RESET;
      end else begin
        st_q <= st_d;
      end
    end

    assign bank_val[b] = st_q;
  end

  // Control, status and enable registers with the link state machine
  logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`IRQ_W-1:0]  stat_q, stat_d, en_q, en_d, set_ev;
  link_state_t        state_q, state_d;
  logic               k_seen_q, k_seen_d;
  logic               req_clr, idle_clr;
  logic               pad_idle_q, pad_idle_d;
  logic               drive_q, drive_d;
  logic               irq_q, irq_d;
  logic               ctrl_on, ctrl_disc, resume_req;

  assign ctrl_on    = ctrl_q[`CTRL_ON_BIT];
  assign ctrl_disc  = ctrl_q[`CTRL_DISC_BIT];
  assign resume_req = ctrl_q[`CTRL_RESUME_REQ_BIT];

  always_comb begin
    state_d  = state_q;
    k_seen_d = k_seen_q;
    set_ev   = '0;
    req_clr  = 1'b0;
    idle_clr = 1'b0;
    if (!ctrl_on || ctrl_disc) begin
      state_d  = st_off;
      k_seen_d = 1'b0;
    end else begin
      unique case (state_q)
        st_off: begin
          state_d = st_active;
        end
        st_active: begin
          if (tmr.done) begin
            state_d                = st_suspend;
            set_ev[`IRQ_IDLE_BIT]  = 1'b1;
          end
        end
        st_suspend: begin
          if (!line_is_j(line)) begin
            state_d               = st_active;
            set_ev[`IRQ_WAKE_BIT] = 1'b1;
            k_seen_d              = line_is_k(line);
          end else if (resume_req && stat_q[`IRQ_IDLE_BIT]) begin
            state_d = st_wait;
          end
        end
        st_wait: begin
          if (!line_is_j(line)) begin
            // Host woke the bus first; the pending request is dropped
            state_d               = st_active;
            set_ev[`IRQ_WAKE_BIT] = 1'b1;
            k_seen_d              = line_is_k(line);
            req_clr               = 1'b1;
          end else if (!resume_req || !stat_q[`IRQ_IDLE_BIT]) begin
            state_d = st_suspend;
          end else if (tmr.done) begin
            state_d               = st_drive;
            set_ev[`IRQ_WAKE_BIT] = 1'b1;
            idle_clr              = 1'b1;
          end
        end
        st_drive: begin
          if (tmr.done) begin
            state_d = st_active;
            req_clr = 1'b1;
          end
        end
      endcase
      // Host resume is over once the line leaves K
      if (state_q == st_active && k_seen_q && !line_is_k(line)) begin
        set_ev[`IRQ_DONE_BIT] = 1'b1;
        k_seen_d              = 1'b0;
      end
    end
  end

  always_comb begin
    tmr.run   = 1'b0;
    tmr.limit = `CNT_W'(SUSPEND_IDLE_CYC);
    unique case (state_q)
      st_active: begin
        tmr.run = line_is_j(line);
      end
      st_wait: begin
        tmr.run   = line_is_j(line);
        tmr.limit = `CNT_W'(RESUME_IDLE_CYC);
      end
      st_drive: begin
        tmr.run   = 1'b1;
        tmr.limit = `CNT_W'(RESUME_K_CYC);
      end
      st_off, st_suspend: begin
        tmr.run = 1'b0;
      end
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wdata_q[`CTRL_W-1:0];
    end
    // Hardware clear wins over a software write in the same cycle
    if (req_clr) begin
      ctrl_d[`CTRL_RESUME_REQ_BIT] = 1'b0;
    end
    en_d = wr_en ? wdata_q[`IRQ_W-1:0] : en_q;
    stat_d = stat_q;
    if (wr_clr) begin
      stat_d = stat_q & ~wdata_q[`IRQ_W-1:0];
    end
    if (idle_clr) begin
      stat_d[`IRQ_IDLE_BIT] = 1'b0;
    end
    stat_d     = stat_d | set_ev;
    drive_d    = (state_d == st_drive);
    pad_idle_d = (state_d == st_off) || (state_d == st_suspend) ||
                 (state_d == st_wait);
    irq_d      = |(stat_d & en_d);
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= `CTRL_RESET;
      stat_q     <= `IRQ_RESET;
      en_q       <= `IRQ_RESET;
      state_q    <= st_off;
      k_seen_q   <= 1'b0;
      drive_q    <= 1'b0;
      pad_idle_q <= 1'b1;
      irq_q      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      stat_q     <= stat_d;
      en_q       <= en_d;
      state_q    <= state_d;
      k_seen_q   <= k_seen_d;
      drive_q    <= drive_d;
      pad_idle_q <= pad_idle_d;
      irq_q      <= irq_d;
    end
  end

  // AXI4-Lite read channel
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid_in && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_mapped(s_axi_araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (addr_hit(s_axi_araddr_in, `CTRL_IDX)) begin
        rdata_d[`CTRL_W-1:0] = ctrl_q;
      end else if (addr_hit(s_axi_araddr_in, `IRQ_STAT_IDX)) begin
        rdata_d[`IRQ_W-1:0] = stat_q;
      end else if (addr_hit(s_axi_araddr_in, `IRQ_EN_IDX)) begin
        rdata_d[`IRQ_W-1:0] = en_q;
      end else if (addr_hit(s_axi_araddr_in, BANK_IDX[0])) begin
        rdata_d[`BANK_W-1:0] = bank_val[0];
      end else if (addr_hit(s_axi_araddr_in, BANK_IDX[1])) begin
        rdata_d[`BANK_W-1:0] = bank_val[1];
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  // K state is dp low, dm high; only driven during upstream resume
  assign usb_dp_out        = 1'b0;
  assign usb_dm_out        = drive_q;
  assign usb_oe_out        = drive_q;
  assign pad_idle_out      = pad_idle_q;
  assign irq_out           = irq_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_pad_forced_idle: assert property ((!ctrl_on || ctrl_disc) |=> pad_idle_q)
    else $error("pad not idle while controller off or disconnected");
  a_suspend_idles: assert property (set_ev[`IRQ_IDLE_BIT] |=> pad_idle_q && stat_q[`IRQ_IDLE_BIT])
    else $error("suspend did not idle pad and set flag");
  a_wake_activates: assert property ((state_q == st_suspend && ctrl_on && !ctrl_disc && !line_is_j(line)) |=> !pad_idle_q && stat_q[`IRQ_WAKE_BIT])
    else $error("wake did not reactivate pad");
  a_resume_gated: assert property ($rose(drive_q) |-> $past(stat_q[`IRQ_IDLE_BIT]) && $past(resume_req))
    else $error("resume sent without suspend flag or request");
  a_resume_flags: assert property ($rose(drive_q) |-> stat_q[`IRQ_WAKE_BIT] && !stat_q[`IRQ_IDLE_BIT])
    else $error("resume did not update wake and idle flags");
  a_k_hold: assert property ($rose(drive_q) |-> drive_q [*8])
    else $error("resume K too short");
  a_req_self_clear: assert property ($fell(drive_q) && !$past(wr_ctrl) |-> !resume_req)
    else $error("resume request not cleared at end of resume");
  a_flow_nak: assert property ((host_mode_in && !bank_iso_in[0] && bank_nak_in[0]) |=> bank_val[0][`BANK_FLOW_BIT])
    else $error("NAK did not set flow fault");
  a_iso_crc: assert property ((host_mode_in && bank_iso_in[1] && bank_rx_dir_in[1] && bank_crc_in[1]) |=> bank_val[1][`BANK_CRC_BIT])
    else $error("iso CRC fault not recorded");
  a_irq_level: assert property (irq_q == |(stat_q & en_q))
    else $error("interrupt output disagrees with status and enable");
  a_read_answer: assert property ((s_axi_arvalid_in && arready_q) |=> rvalid_q)
    else $error("read not answered in one cycle");

  c_suspend: cover property (set_ev[`IRQ_IDLE_BIT]);
  c_resume_sent: cover property ($fell(drive_q));
  c_host_resume_done: cover property (set_ev[`IRQ_DONE_BIT]);
  c_flow_iso: cover property (bank_val[0][`BANK_FLOW_BIT] && bank_iso_in[0]);

endmodule

// ==== tb/usb_host_model.sv ====
// Upstream host model: drives the bus lines and merges in the device's drive
`timescale 1ns/1ps

module usb_host_model (
  input  wire logic clk_in,
  input  wire logic dev_oe_in,
  input  wire logic dev_dp_in,
  input  wire logic dev_dm_in,
  output logic      dp_out,
  output logic      dm_out
);
  logic k_q;

  // Host has already enabled remote wakeup before suspending the bus
  assign dp_out = dev_oe_in ? dev_dp_in : !k_q;
  assign dm_out = dev_oe_in ? dev_dm_in : k_q;

  initial k_q = 1'b0;

  // Resume K from the host; the bus returns to J (pull-up) afterwards
  task automatic send_k(input int n);
    @(posedge clk_in);
    k_q <= 1'b1;
    repeat (n) @(posedge clk_in);
    k_q <= 1'b0;
  endtask
endmodule

// ==== tb/usb_suspend_resume_ctrl_tb_top.sv ====
// Self-checking bench for the suspend/resume controller
`timescale 1ns/1ps

module usb_suspend_resume_ctrl_tb_top;
  logic        clk, nrst, awv, wv, bry, arv, rry, hm;
  logic [11:0] awa, ara;
  logic [31:0] wd;
  logic [1:0]  nak, ovr, udf, crc, iso, dir;
  logic        awr, wr_rdy, bv, arr, rv, dpo, dmo, oe, idle, irq, dpl, dml;
  logic [1:0]  br, rr;
  logic [31:0] rd_d;
  logic [33:0] exp_q[$];
  logic [1:0]  bq[$];
  logic [3:0]  ws;
  logic [16:0] r;
  int          fails, tests_run, n;

  usb_suspend_resume_ctrl #(.SUSPEND_IDLE_CYC(20), .RESUME_IDLE_CYC(30), .RESUME_K_CYC(16)) dut (
    .core_clk_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd_d),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .usb_dp_in(dpl), .usb_dm_in(dml), .usb_dp_out(dpo), .usb_dm_out(dmo),
    .usb_oe_out(oe), .pad_idle_out(idle), .host_mode_in(hm), .bank_nak_in(nak),
    .bank_overrun_in(ovr), .bank_underflow_in(udf), .bank_crc_in(crc),
    .bank_iso_in(iso), .bank_rx_dir_in(dir), .irq_out(irq));

  usb_host_model host (.clk_in(clk), .dev_oe_in(oe), .dev_dp_in(dpo), .dev_dm_in(dmo),
    .dp_out(dpl), .dm_out(dml));

  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] eb = 2'h0);
    logic pa, pw;
    bq.push_back(eb);
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr) begin awv <= 1'b0; pa = 1'b0; end
      if (pw && wr_rdy) begin wv <= 1'b0; pw = 1'b0; end
    end
    bry <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
  endtask

  // The expected word is noted here; the monitor compares it when rvalid shows
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    ara <= a; arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0; rry <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 1'b0;
  endtask

  task automatic pulse(input int b, input logic [3:0] k);
    @(posedge clk);
    nak[b] <= k[0]; ovr[b] <= k[1]; crc[b] <= k[2]; udf[b] <= k[3];
    @(posedge clk);
    nak <= 2'h0; ovr <= 2'h0; crc <= 2'h0; udf <= 2'h0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rv === 1'b1 && rry === 1'b1) check("rdata", {rr, rd_d}, exp_q.pop_front());
    if (bv === 1'b1 && bry === 1'b1) check("bresp", br, bq.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    {nrst, awv, wv, bry, arv, rry, hm} = 7'h00;
    {awa, ara, wd, nak, ovr, udf, crc, iso, dir} = '0;
    ws = 4'hF;
    r = 17'd66914;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h004, 34'h0);
    rd(12'h000, 34'h0);
    check("pad_idle", idle, 1'b1);
    wr(12'h00C, 32'h7);
    wr(12'h000, 32'h1);
    repeat (4) @(posedge clk);
    check("pad_idle", idle, 1'b0);
    repeat (30) @(posedge clk);
    check("pad_idle", idle, 1'b1);
    check("irq", irq, 1'b1);
    rd(12'h004, 34'h1);
    wr(12'h00C, 32'h0);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    wr(12'h00C, 32'h7);
    wr(12'h008, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    host.send_k(5);
    repeat (4) @(posedge clk);
    check("pad_idle", idle, 1'b0);
    rd(12'h004, 34'h6);
    wr(12'h008, 32'h7);
    repeat (30) @(posedge clk);
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h5);
    repeat (50) @(posedge clk);
    check("oe no suspend flag", oe, 1'b0);
    host.send_k(3);
    wr(12'h008, 32'h7);
    n = 0;
    while (oe !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    check("resume delay", n >= 50, 1'b1);
    check("k dm", dmo, 1'b1);
    check("k dp", dpo, 1'b0);
    rd(12'h004, 34'h6);
    n = 0;
    while (oe === 1'b1 && n < 200) begin @(posedge clk); n++; end
    check("k length", n >= 12, 1'b1);
    rd(12'h000, 34'h1);
    wr(12'h000, 32'h3);
    repeat (3) @(posedge clk);
    check("pad_idle", idle, 1'b1);
    hm <= 1'b1; iso <= 2'b10; dir <= 2'b10;
    pulse(0, 3'b001);
    pulse(1, 3'b101);
    rd(12'h068, 34'h1);
    pulse(1, 3'b010);
    rd(12'h028, 34'h2);
    rd(12'h068, 34'h3);
    iso <= 2'b11;
    wr(12'h028, 32'h0);
    pulse(0, 4'b1000);
    rd(12'h028, 34'h2);
    r = lfsr(r);
    wr(12'h028, {15'h0000, r});
    // Byte lane 0 off: the bank must keep the random value
    ws <= 4'hE;
    wr(12'h028, 32'h3);
    ws <= 4'hF;
    rd(12'h028, {32'h0, r[1:0]});
    wr(12'h100, 32'h1, 2'h2);
    rd(12'h100, 34'h200000000);
    results();
  end
endmodule
